// *** rtl/dram_wl_pkg.sv ***
// Constants shared by both ends of the write leveling link
package dram_wl_pkg;
  // Clock and link timing, times in ns
  localparam int CLK_NS = 4;
  localparam int T_MOD_NS = 60;
  localparam int T_MRD_NS = 16;
  localparam int T_WLDQSEN_NS = 100;
  localparam int T_WLMRD_NS = 160;
  localparam int T_DQSL_NS = 16;
  localparam int T_DQSH_NS = 16;
  // Least times round up to whole cycles
  localparam int MOD_CYC = (T_MOD_NS + CLK_NS - 1) / CLK_NS;
  localparam int MRD_CYC = (T_MRD_NS + CLK_NS - 1) / CLK_NS;
  localparam int WLDQSEN_CYC = (T_WLDQSEN_NS + CLK_NS - 1) / CLK_NS;
  localparam int WLMRD_CYC = (T_WLMRD_NS + CLK_NS - 1) / CLK_NS;
  localparam int DQSL_CYC = (T_DQSL_NS + CLK_NS - 1) / CLK_NS;
  localparam int DQSH_CYC = (T_DQSH_NS + CLK_NS - 1) / CLK_NS;
  // Link clock half period in system cycles, 64 ns period
  localparam int CK_HALF = 8;
  // Cycles the command strobe is held so the far end catches it
  localparam int MRS_HOLD = 4;
  // Cycles per leveling trial, covers max tap plus feedback return
  localparam int TRIAL_LEN = 64;
  // Mode register selects and bit positions
  localparam logic [2:0] MR1_SEL = 3'h1;
  localparam logic [2:0] MR2_SEL = 3'h2;
  localparam int MR1_WL_BIT = 7;
  localparam int MR1_QOFF_BIT = 12;
  localparam int MR2_ASR_BIT = 6;
  localparam int MR2_SRT_BIT = 7;
  // Delay taps per lane
  localparam int TAP_W = 5;
  localparam int LANES = 2;
  // Controller register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_MR2 = 8'h08;
  localparam logic [7:0] REG_TAPS = 8'h0c;
  // Control register fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_QOFF_BIT = 1;
  localparam int CTRL_HOT_BIT = 2;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** rtl/wl_if.sv ***
// Pin bundle between the leveling controller and the DRAM end
`timescale 1ns/10ps
interface wl_if;
  logic ck; // Link clock from controller divider
  logic mrs; // Mode register set strobe, held MRS_HOLD cycles
  logic [2:0] ba; // Mode register select
  logic [12:0] addr; // Mode register value
  logic odt; // Termination request
  logic [1:0] dqs; // Strobe per lane, true side
  logic [1:0] dqs_oe; // Strobe drive enable per lane
  logic [15:0] dq; // Feedback data from DRAM
  logic dq_oe; // DRAM drives data pins
  modport dev(input ck, mrs, ba, addr, odt, dqs, dqs_oe, output dq, dq_oe);
  modport ctl(output ck, mrs, ba, addr, odt, dqs, dqs_oe, input dq, dq_oe);
endinterface // wl_if

// *** rtl/dram_wl_device.sv ***
// DRAM end: mode bits, leveling termination and clock feedback
`timescale 1ns/10ps
module dram_wl_device
  import dram_wl_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  wl_if.dev LINK,
  input wire logic PRIME_ONLY_IN,
  output logic LEVELING_OUT,
  output logic OUTPUT_OFF_OUT,
  output logic RTT_DQS_ON_OUT,
  output logic RTT_DQ_ON_OUT,
  output logic AUTO_SR_OUT,
  output logic SR_EXT_OUT,
  output logic DQ_UNDEF_OUT
);
  logic [4:0] s1_q; // First sync stage, read by s2 only
  logic [4:0] s2_q; // {ck, odt, mrs, dqs[1:0]} synchronised
  logic [4:0] prev_q; // Last synced value for edges
  logic [2:0] ba_s1_q; // Register select, first sync stage
  logic [2:0] ba_s2_q; // Register select, synchronised
  logic [12:0] addr_s1_q; // Register value, first sync stage
  logic [12:0] addr_s2_q; // Register value, synchronised
  logic level_q; // Leveling mode
  logic qoff_q; // Output buffer off
  logic asr_q; // Auto self refresh
  logic srt_q; // Extended self refresh range
  logic [7:0] mod_cnt_q; // tMOD after entry, gates ODT
  logic [7:0] undef_cnt_q; // tMOD after exit, DQ stays undefined
  logic [LANES-1:0] fb_q; // Sampled clock per lane
  logic seen_q; // A strobe edge has been sampled
  logic rtt_dqs_q;
  logic rtt_dq_q;
  logic mrs_rise;
  logic [LANES-1:0] dqs_rise;

  // Two flops on every pin from the controller
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
      prev_q <= 5'h00;
      ba_s1_q <= 3'h0;
      ba_s2_q <= 3'h0;
      addr_s1_q <= 13'h0000;
      addr_s2_q <= 13'h0000;
    end else begin
      s1_q <= {LINK.ck, LINK.odt, LINK.mrs, LINK.dqs & LINK.dqs_oe};
      s2_q <= s1_q;
      prev_q <= s2_q;
      // Select and value settle a cycle before the strobe, so they are synced in time
      ba_s1_q <= LINK.ba;
      ba_s2_q <= ba_s1_q;
      addr_s1_q <= LINK.addr;
      addr_s2_q <= addr_s1_q;
    end
  end

  assign mrs_rise = s2_q[2] & ~prev_q[2];
  assign dqs_rise = s2_q[1:0] & ~prev_q[1:0];

  // Mode register writes; address is held stable around the strobe
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      level_q <= 1'b0;
      qoff_q <= 1'b0;
      asr_q <= 1'b0;
      srt_q <= 1'b0;
    end else if (mrs_rise) begin
      if (ba_s2_q == MR1_SEL) begin
        level_q <= addr_s2_q[MR1_WL_BIT];
        qoff_q <= addr_s2_q[MR1_QOFF_BIT];
      end else if (ba_s2_q == MR2_SEL) begin
        asr_q <= addr_s2_q[MR2_ASR_BIT];
        srt_q <= addr_s2_q[MR2_SRT_BIT];
      end
    end
  end

  // ODT is ignored until tMOD after the entry command
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      mod_cnt_q <= 8'h00;
    end else if (mrs_rise && ba_s2_q == MR1_SEL && addr_s2_q[MR1_WL_BIT]) begin
      mod_cnt_q <= 8'(MOD_CYC);
    end else if (mod_cnt_q != 8'h00) begin
      mod_cnt_q <= mod_cnt_q - 8'h01;
    end
  end

  // Exit leaves DQ undefined for tMOD
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      undef_cnt_q <= 8'h00;
    end else if (mrs_rise && ba_s2_q == MR1_SEL && level_q && !addr_s2_q[MR1_WL_BIT]) begin
      undef_cnt_q <= 8'(MOD_CYC);
    end else if (undef_cnt_q != 8'h00) begin
      undef_cnt_q <= undef_cnt_q - 8'h01;
    end
  end

  // Termination: strobes only while leveling, well inside tWLDQSEN
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      rtt_dqs_q <= 1'b0;
      rtt_dq_q <= 1'b0;
    end else if (level_q) begin
      rtt_dqs_q <= s2_q[3] && mod_cnt_q == 8'h00;
      rtt_dq_q <= 1'b0;
    end else begin
      rtt_dqs_q <= s2_q[3];
      rtt_dq_q <= s2_q[3];
    end
  end

  // Each lane samples the clock on its own strobe rise
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      fb_q <= '0;
      seen_q <= 1'b0;
    end else if (!level_q) begin
      seen_q <= 1'b0;
    end else begin
      for (int l = 0; l < LANES; l++) begin
        if (dqs_rise[l]) begin
          fb_q[l] <= s2_q[4];
        end
      end
      if (|dqs_rise) begin
        seen_q <= 1'b1;
      end
    end
  end

  // Feedback onto the byte lanes, combinational from the sample with no added cycle
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      if (PRIME_ONLY_IN) begin
        LINK.dq[l*8 +: 8] = {7'h00, fb_q[l]};
      end else begin
        LINK.dq[l*8 +: 8] = {8{fb_q[l]}};
      end
    end
  end

  // Buffer off keeps the pins released
  assign LINK.dq_oe = (level_q || undef_cnt_q != 8'h00) && !qoff_q;
  assign LEVELING_OUT = level_q;
  assign OUTPUT_OFF_OUT = qoff_q;
  assign RTT_DQS_ON_OUT = rtt_dqs_q;
  assign RTT_DQ_ON_OUT = rtt_dq_q;
  assign AUTO_SR_OUT = asr_q;
  assign SR_EXT_OUT = srt_q;
  assign DQ_UNDEF_OUT = (level_q && !seen_q) || undef_cnt_q != 8'h00;
endmodule // dram_wl_device

// *** rtl/dram_wl_ctrl.sv ***
// Controller end: AXI4-Lite registers and the leveling sequencer
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
module dram_wl_ctrl
  import dram_wl_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  wl_if.ctl LINK,
  input wire logic [7:0] AXI_AWADDR_IN,
  input wire logic AXI_AWVALID_IN,
  output logic AXI_AWREADY_OUT,
  input wire logic [31:0] AXI_WDATA_IN,
  input wire logic [3:0] AXI_WSTRB_IN,
  input wire logic AXI_WVALID_IN,
  output logic AXI_WREADY_OUT,
  output logic [1:0] AXI_BRESP_OUT,
  output logic AXI_BVALID_OUT,
  input wire logic AXI_BREADY_IN,
  input wire logic [7:0] AXI_ARADDR_IN,
  input wire logic AXI_ARVALID_IN,
  output logic AXI_ARREADY_OUT,
  output logic [31:0] AXI_RDATA_OUT,
  output logic [1:0] AXI_RRESP_OUT,
  output logic AXI_RVALID_OUT,
  input wire logic AXI_RREADY_IN,
  output logic REFRESH_2X_OUT,
  output logic SELF_REFRESH_OK_OUT
);
  typedef enum logic [3:0] {
    S_IDLE, S_MRS, S_WAIT, S_ODT_ON, S_DQS_LOW, S_ALIGN, S_TRIAL, S_STROBE_OFF,
    S_ODT_OFF, S_EXIT_MRS
  } state_t;

  state_t state_q; // Sequencer state
  state_t nxt_q; // State after the current wait
  logic [7:0] cnt_q; // Hold or wait counter
  logic [7:0] wait_q; // Wait loaded after the command hold
  logic [7:0] t_q; // Cycle within a trial
  logic [3:0] div_q; // Link clock divider
  logic ck_q;
  logic [TAP_W-1:0] tap_q [LANES]; // Strobe delay per lane
  logic [LANES-1:0] prev_fb_q; // Last sample per lane
  logic [LANES-1:0] lock_q;
  logic fail_q;
  logic done_q;
  logic [LANES-1:0] fb_s1_q; // First sync stage
  logic [LANES-1:0] fb_s2_q;
  logic mrs_q;
  logic [2:0] ba_q;
  logic [12:0] addr_q;
  logic odt_q;
  logic [LANES-1:0] dqs_q;
  logic [LANES-1:0] dqs_oe_q;
  // Register file
  logic start_q; // Start request pending
  logic qoff_q; // Leave this rank's buffer off
  logic hot_q; // Case above the normal range
  logic asr_q;
  logic srt_q;
  logic mr2_pend_q; // MR2 write pending
  // AXI slave state
  logic aw_hold_q;
  logic w_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wstrb0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_fire;
  logic busy;
  logic map_ok;

  assign busy = state_q != S_IDLE;

  // Free-running link clock from the system clock
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      div_q <= 4'h0;
      ck_q <= 1'b0;
    end else if (div_q == 4'(CK_HALF - 1)) begin
      div_q <= 4'h0;
      ck_q <= ~ck_q;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  // Feedback pins cross in through two flops, prime bit per lane
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      fb_s1_q <= '0;
      fb_s2_q <= '0;
    end else begin
      fb_s1_q <= {LINK.dq[8] & LINK.dq_oe, LINK.dq[0] & LINK.dq_oe};
      fb_s2_q <= fb_s1_q;
    end
  end

  // Sequencer; only the entry and exit MRS go out while leveling
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      state_q <= S_IDLE;
      nxt_q <= S_IDLE;
      cnt_q <= 8'h00;
      wait_q <= 8'h00;
      t_q <= 8'h00;
      mrs_q <= 1'b0;
      ba_q <= 3'h0;
      addr_q <= 13'h0000;
      odt_q <= 1'b0;
      dqs_oe_q <= '0;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (start_q) begin
            ba_q <= MR1_SEL;
            addr_q <= 13'h0000; // No nominal termination value sent
            addr_q[MR1_WL_BIT] <= 1'b1;
            addr_q[MR1_QOFF_BIT] <= qoff_q;
            wait_q <= 8'(MOD_CYC);
            nxt_q <= S_ODT_ON;
            cnt_q <= 8'(MRS_HOLD);
            state_q <= S_MRS;
          end else if (mr2_pend_q) begin // MR2 only from idle
            ba_q <= MR2_SEL;
            addr_q <= 13'h0000;
            addr_q[MR2_ASR_BIT] <= asr_q;
            addr_q[MR2_SRT_BIT] <= srt_q;
            wait_q <= 8'(MRD_CYC);
            nxt_q <= S_IDLE;
            cnt_q <= 8'(MRS_HOLD);
            state_q <= S_MRS;
          end
        end
        S_MRS: begin
          // Strobe held with a stable address, then the wait
          mrs_q <= cnt_q != 8'h00;
          if (cnt_q == 8'h00) begin
            cnt_q <= wait_q;
            state_q <= S_WAIT;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        S_WAIT: begin
          if (cnt_q == 8'h00) begin
            state_q <= nxt_q;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        S_ODT_ON: begin
          odt_q <= 1'b1;
          cnt_q <= 8'(WLDQSEN_CYC);
          nxt_q <= S_DQS_LOW;
          state_q <= S_WAIT;
        end
        S_DQS_LOW: begin
          dqs_oe_q <= '1;
          cnt_q <= 8'(DQSL_CYC + WLMRD_CYC);
          nxt_q <= S_ALIGN;
          state_q <= S_WAIT;
        end
        S_ALIGN: begin
          // Trials start at a fixed link clock phase
          t_q <= 8'h00;
          if (div_q == 4'h0 && !ck_q) begin
            state_q <= S_TRIAL;
          end
        end
        S_TRIAL: begin
          t_q <= t_q + 8'h01;
          if (t_q == 8'(TRIAL_LEN - 1)) begin
            state_q <= ((&(lock_q | LANES'(fb_s2_q & ~prev_fb_q))) || fail_q) ?
                       S_STROBE_OFF : S_ALIGN;
          end
        end
        S_STROBE_OFF: begin
          dqs_oe_q <= '0;
          state_q <= S_ODT_OFF;
        end
        S_ODT_OFF: begin
          odt_q <= 1'b0;
          cnt_q <= 8'(WLDQSEN_CYC);
          nxt_q <= S_EXIT_MRS;
          state_q <= S_WAIT;
        end
        S_EXIT_MRS: begin
          ba_q <= MR1_SEL;
          addr_q <= 13'h0000;
          addr_q[MR1_QOFF_BIT] <= qoff_q;
          wait_q <= 8'(MOD_CYC > MRD_CYC ? MOD_CYC : MRD_CYC);
          nxt_q <= S_IDLE;
          cnt_q <= 8'(MRS_HOLD);
          state_q <= S_MRS;
        end
      endcase
    end
  end

  // One rising edge per lane per trial, delayed by that lane's tap
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      dqs_q <= '0;
    end else begin
      for (int l = 0; l < LANES; l++) begin
        dqs_q[l] <= state_q == S_TRIAL && t_q >= 8'(tap_q[l]) &&
                    t_q < 8'(tap_q[l]) + 8'(DQSH_CYC);
      end
    end
  end

  // Per-lane step and lock on a 0-to-1 change of feedback
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      for (int l = 0; l < LANES; l++) begin
        tap_q[l] <= '0;
      end
      prev_fb_q <= '1;
      lock_q <= '0;
      fail_q <= 1'b0;
      done_q <= 1'b0;
    end else if (state_q == S_IDLE && start_q) begin
      for (int l = 0; l < LANES; l++) begin
        tap_q[l] <= '0;
      end
      prev_fb_q <= '1; // First sample cannot count as an edge
      lock_q <= '0;
      fail_q <= 1'b0;
      done_q <= 1'b0;
    end else if (state_q == S_TRIAL && t_q == 8'(TRIAL_LEN - 1)) begin
      for (int l = 0; l < LANES; l++) begin
        if (!lock_q[l]) begin
          prev_fb_q[l] <= fb_s2_q[l];
          if (!prev_fb_q[l] && fb_s2_q[l]) begin
            lock_q[l] <= 1'b1;
          end else if (tap_q[l] == '1) begin
            fail_q <= 1'b1;
          end else begin
            tap_q[l] <= tap_q[l] + 1'b1;
          end
        end
      end
    end else if (state_q == S_WAIT && nxt_q == S_IDLE && cnt_q == 8'h00 && ba_q == MR1_SEL) begin
      done_q <= 1'b1;
    end
  end

  // AXI write: address and data taken in either order
  assign AXI_AWREADY_OUT = !aw_hold_q && !bvalid_q;
  assign AXI_WREADY_OUT = !w_hold_q && !bvalid_q;
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (AXI_AWVALID_IN && AXI_AWREADY_OUT) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= AXI_AWADDR_IN;
      end
      if (AXI_WVALID_IN && AXI_WREADY_OUT) begin
        w_hold_q <= 1'b1;
        wdata_q <= AXI_WDATA_IN;
        wstrb0_q <= AXI_WSTRB_IN[0];
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (awaddr_q == REG_CTRL || awaddr_q == REG_MR2) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && AXI_BREADY_IN) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Register effects; requests made while busy wait their turn
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      start_q <= 1'b0;
      qoff_q <= 1'b0;
      hot_q <= 1'b0;
      asr_q <= 1'b0;
      srt_q <= 1'b0;
      mr2_pend_q <= 1'b0;
    end else begin
      if (state_q == S_IDLE && start_q) begin
        start_q <= 1'b0;
      end else if (state_q == S_IDLE && mr2_pend_q) begin
        mr2_pend_q <= 1'b0;
      end
      if (wr_fire && wstrb0_q && awaddr_q == REG_CTRL) begin
        // A write without start must not revive a request being taken
        if (wdata_q[CTRL_START_BIT]) begin
          start_q <= 1'b1;
        end
        qoff_q <= wdata_q[CTRL_QOFF_BIT];
        hot_q <= wdata_q[CTRL_HOT_BIT];
      end
      if (wr_fire && wstrb0_q && awaddr_q == REG_MR2) begin
        asr_q <= wdata_q[0];
        srt_q <= wdata_q[1] & ~wdata_q[0];
        mr2_pend_q <= 1'b1;
      end
    end
  end

  // AXI read: answer one cycle after the address is taken
  assign AXI_ARREADY_OUT = !rvalid_q;
  assign map_ok = AXI_ARADDR_IN == REG_CTRL || AXI_ARADDR_IN == REG_STAT ||
                  AXI_ARADDR_IN == REG_MR2 || AXI_ARADDR_IN == REG_TAPS;
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else if (AXI_ARVALID_IN && AXI_ARREADY_OUT) begin
      rvalid_q <= 1'b1;
      rresp_q <= map_ok ? RESP_OKAY : RESP_SLVERR;
      unique case (AXI_ARADDR_IN)
        REG_CTRL: rdata_q <= {29'h0, hot_q, qoff_q, start_q};
        REG_STAT: rdata_q <= {26'h0, mr2_pend_q, fail_q, lock_q, done_q, busy};
        REG_MR2: rdata_q <= {30'h0, srt_q, asr_q};
        REG_TAPS: rdata_q <= {19'h0, tap_q[1], 3'h0, tap_q[0]};
        default: rdata_q <= 32'h00000000;
      endcase
    end else if (rvalid_q && AXI_RREADY_IN) begin
      rvalid_q <= 1'b0;
    end
  end

  assign AXI_BVALID_OUT = bvalid_q;
  assign AXI_BRESP_OUT = bresp_q;
  assign AXI_RVALID_OUT = rvalid_q;
  assign AXI_RDATA_OUT = rdata_q;
  assign AXI_RRESP_OUT = rresp_q;
  // Refresh and self refresh advice for the hot case
  assign REFRESH_2X_OUT = hot_q;
  assign SELF_REFRESH_OK_OUT = !hot_q || asr_q || srt_q;
  // Link pins
  assign LINK.ck = ck_q;
  assign LINK.mrs = mrs_q;
  assign LINK.ba = ba_q;
  assign LINK.addr = addr_q;
  assign LINK.odt = odt_q;
  assign LINK.dqs = dqs_q;
  assign LINK.dqs_oe = dqs_oe_q;
endmodule // dram_wl_ctrl

// *** verification/dram_wl_checker.sv ***
// Timing checks on the pins between the leveling controller and the DRAM end
`timescale 1ns/10ps
module dram_wl_checker
  import dram_wl_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic ck,
  input wire logic mrs,
  input wire logic [2:0] ba,
  input wire logic [12:0] addr,
  input wire logic odt,
  input wire logic [1:0] dqs,
  input wire logic [1:0] dqs_oe,
  input wire logic [15:0] dq,
  input wire logic dq_oe
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  int unsigned mrs_age_q; // Cycles since the command strobe dropped
  int unsigned odt_age_q; // Cycles termination has been requested
  // Age since last command, saturates so it never wraps
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN || mrs) begin
      mrs_age_q <= 0;
    end else if (mrs_age_q < 999) begin
      mrs_age_q <= mrs_age_q + 1;
    end
  end
  // Age of the termination request
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN || !odt) begin
      odt_age_q <= 0;
    end else if (odt_age_q < 999) begin
      odt_age_q <= odt_age_q + 1;
    end
  end
  // Command steps of entry and exit
  sequence s_entry_on;
    $rose(mrs) && ba == MR1_SEL && addr[MR1_WL_BIT] && !addr[MR1_QOFF_BIT];
  endsequence
  sequence s_entry_off;
    $rose(mrs) && ba == MR1_SEL && addr[MR1_WL_BIT] && addr[MR1_QOFF_BIT];
  endsequence
  sequence s_exit_cmd;
    $rose(mrs) && ba == MR1_SEL && !addr[MR1_WL_BIT];
  endsequence
  a_mrs_width: assert property ($rose(mrs) |-> mrs[*4] ##1 !mrs)
    else $error("command strobe width wrong");
  a_cmd_stable: assert property (mrs |-> $stable(ba) && $stable(addr))
    else $error("command fields moved under strobe");
  a_odt_after_mod: assert property ($rose(odt) |-> mrs_age_q >= MOD_CYC - 2)
    else $error("termination requested too early");
  a_dqs_after_odt: assert property ($rose(dqs_oe[0]) |-> odt && odt_age_q >= WLDQSEN_CYC - 2)
    else $error("strobes driven before termination settled");
  a_no_cmd_busy: assert property (dqs_oe != 2'h0 |-> !mrs)
    else $error("command issued while strobes driven");
  a_exit_order: assert property (s_exit_cmd |-> !odt && dqs_oe == 2'h0 && !$past(odt, 8))
    else $error("exit command before strobes and termination off");
  a_strobe_high: assert property ($rose(dqs[0]) |-> dqs[0][*4] ##1 !dqs[0])
    else $error("lower strobe pulse width wrong");
  a_strobe_low: assert property ($fell(dqs[1]) |-> !dqs[1][*8])
    else $error("upper strobe low phase too short");
  a_entry_feedback: assert property (s_entry_on |-> ##[1:8] dq_oe)
    else $error("data pins not driven after entry");
  a_qoff_quiet: assert property (s_entry_off |-> !dq_oe[*8])
    else $error("data pins driven with buffer off");
  a_ck_half: assert property ($rose(ck) |-> ck[*8] ##1 !ck)
    else $error("link clock half period wrong");
endmodule // dram_wl_checker

// *** verification/tb_top.sv ***
// Self-checking bench joining the leveling controller and the DRAM end
`timescale 1ns/10ps
module tb_top
  import dram_wl_pkg::*;
;
  logic clk = 0, rst = 1, prime = 1; // Clock, reset, feedback style
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, r2x, srok;
  logic lev, qoff_o, rtt_dqs, rtt_dq, asr_o, srt_o, undef;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  int err_count = 0, n_compared = 0;
  wl_if link_if();
  dram_wl_ctrl dram_wl_ctrl_inst (.CLK_IN(clk), .SYS_RST_IN(rst), .LINK(link_if),
    .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid), .AXI_AWREADY_OUT(awready),
    .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(wstrb), .AXI_WVALID_IN(wvalid),
    .AXI_WREADY_OUT(wready), .AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bvalid),
    .AXI_BREADY_IN(bready), .AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arvalid),
    .AXI_ARREADY_OUT(arready), .AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp),
    .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(rready), .REFRESH_2X_OUT(r2x),
    .SELF_REFRESH_OK_OUT(srok));
  dram_wl_device dram_wl_device_inst (.CLK_IN(clk), .SYS_RST_IN(rst), .LINK(link_if),
    .PRIME_ONLY_IN(prime), .LEVELING_OUT(lev), .OUTPUT_OFF_OUT(qoff_o),
    .RTT_DQS_ON_OUT(rtt_dqs), .RTT_DQ_ON_OUT(rtt_dq), .AUTO_SR_OUT(asr_o),
    .SR_EXT_OUT(srt_o), .DQ_UNDEF_OUT(undef));
  dram_wl_checker dram_wl_checker_inst (.CLK_IN(clk), .SYS_RST_IN(rst), .ck(link_if.ck),
    .mrs(link_if.mrs), .ba(link_if.ba), .addr(link_if.addr), .odt(link_if.odt),
    .dqs(link_if.dqs), .dqs_oe(link_if.dqs_oe), .dq(link_if.dq), .dq_oe(link_if.dq_oe));
  // 250 MHz system clock
  always #2 clk = ~clk;
  // Compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Verdict, reached from the tests and from the watchdog
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // One write; ready sampled at the falling edge so no race with the rise
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic pa, pw, ta, tw, tb;
    pa = 1;
    pw = 1;
    tb = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pa || pw) begin
      @(negedge clk);
      ta = awready;
      tw = wready;
      @(posedge clk);
      if (ta && pa) begin
        awvalid <= 1'b0;
        pa = 0;
      end
      if (tw && pw) begin
        wvalid <= 1'b0;
        pw = 0;
      end
    end
    while (!tb) begin
      @(negedge clk);
      tb = bvalid;
      resp = bresp;
      @(posedge clk);
    end
    bready <= 1'b0;
  endtask
  // One read, data and response taken at the handshake
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    logic pa, tr;
    pa = 1;
    tr = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (pa) begin
      @(negedge clk);
      tr = arready;
      @(posedge clk);
      if (tr) begin
        arvalid <= 1'b0;
        pa = 0;
      end
    end
    tr = 0;
    while (!tr) begin
      @(negedge clk);
      tr = rvalid;
      v = rdata;
      resp = rresp;
      @(posedge clk);
    end
    rready <= 1'b0;
  endtask
  // Poll one status bit until it reaches a level
  task automatic wait_stat(input int k, input logic v);
    d[k] = ~v;
    while (d[k] !== v) rd(REG_STAT, d, r);
  endtask
  // One leveling pass with buffer-off choice q and prime-bit feedback p
  task automatic lvl(input logic q, input logic p);
    prime <= p;
    wr(REG_CTRL, {30'h0, q, 1'b1}, r);
    for (int n = 0; n < 200 && link_if.odt !== 1'b1; n++) @(negedge clk);
    chk(undef, 1'b1);
    repeat (WLDQSEN_CYC + 200) @(negedge clk);
    chk(lev, 1'b1);
    chk(qoff_o, q);
    chk({rtt_dqs, rtt_dq}, 2'h2);
    chk(undef, 1'b0);
    chk(link_if.dq_oe, !q);
    if (!q) begin
      chk(p ? {link_if.dq[15:9], link_if.dq[7:1]} : {link_if.dq[15:9] ^ {7{link_if.dq[8]}},
        link_if.dq[7:1] ^ {7{link_if.dq[0]}}}, 32'h0);
    end
    wait_stat(1, 1'b1);
    chk(d[4:0], q ? 5'h12 : 5'h0e);
    if (!q) begin
      rd(REG_TAPS, d, r);
      chk(d[12:8], d[4:0]);
      chk(d[4:0] > 0 && d[4:0] < 16, 1'b1);
    end
    repeat (MOD_CYC + 10) @(negedge clk);
    chk({lev, rtt_dqs, undef, link_if.dq_oe}, 4'h0);
    chk(qoff_o, q);
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(8'(i * 4), d, r);
      chk(d, 32'h0);
      chk(r, RESP_OKAY);
    end
    rd(8'h10, d, r);
    chk({r, d[29:0]}, {RESP_SLVERR, 30'h0});
    for (int i = 1; i < 4; i++) begin
      wr(8'(i == 2 ? 16 : i * 4), 32'h3, r); // hits STAT, unmapped, TAPS in turn
      chk(r, RESP_SLVERR);
    end
    wstrb <= 4'he;
    wr(REG_CTRL, 32'h4, r);
    wstrb <= 4'hf;
    chk({r, r2x}, {RESP_OKAY, 1'b0});
    wr(REG_CTRL, 32'h4, r);
    @(negedge clk);
    chk({r2x, srok}, 2'h2);
    for (int i = 0; i < 4; i++) begin
      wr(REG_MR2, 32'(i), r);
      wait_stat(5, 1'b0);
      repeat (16) @(negedge clk);
      chk({asr_o, srt_o}, {i[0], i[1] & !i[0]});
      chk(srok, i[0] | (i[1] & !i[0]));
      rd(REG_MR2, d, r);
      chk(d[1:0], {i[1] & !i[0], i[0]});
    end
    wr(REG_CTRL, 32'h0, r);
    @(negedge clk);
    chk({r2x, srok}, 2'h1);
    lvl(1'b0, 1'b1);
    lvl(1'b0, 1'b0);
    lvl(1'b1, 1'b1);
    report_and_stop;
  end
  // Watchdog, well past the longest expected run
  initial begin
    #200000;
    err_count++;
    report_and_stop;
  end
endmodule // tb_top
